// ==== shared/pibcw_pkg.sv ====
// Operation
// - Microframe 7 count goes to top pair bits 63..52.
// - Microframe 6 count goes to top pair bits 51..40.
// - Microframe 5 count bits 11..4 go to top pair bits 39..32.
// - Microframe 5 count bits 3..0 go to top pair bits 31..28.
// - Microframe 4 count goes to top pair bits 27..16.
// - Microframe 3 count goes to top pair bits 15..4.
// - Microframe 2 count bits 11..8 go to top pair bits 3..0.
// - Microframe 2 count bits 7..0 go to middle pair bits 63..56.
// - Microframe 1 count goes to middle pair bits 55..44.
// - Microframe 0 count goes to middle pair bits 43..32.
// - Count captures only with its mask bit set and frame matching; descriptor load in idle clears it.
// - Mask checked only on frame match; transaction per set mask bit.
// - Software sets mask bits; controller clears each after processing.
package pibcw_pkg;
  localparam int CNT_W = 12;
  localparam int BYTES_W = 16;
  localparam int UF_NUM = 8;
  localparam int FRAME_W = 5;
  localparam int MASK_W = 8;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam logic [MASK_W-1:0] MASK_RST = 8'h00;
  localparam logic [FRAME_W-1:0] FRAME_RST = 5'h00;
  localparam logic [63:0] PAIR_RST = 64'h0000000000000000;
  // Field positions inside the top pair
  localparam int UF7_LSB = 52;
  localparam int UF6_LSB = 40;
  localparam int UF5H_LSB = 32;
  localparam int UF5L_LSB = 28;
  localparam int UF4_LSB = 16;
  localparam int UF3_LSB = 4;
  localparam int UF2H_LSB = 0;
  // Field positions inside the middle pair
  localparam int UF2L_LSB = 56;
  localparam int UF1_LSB = 44;
  localparam int UF0_LSB = 32;
  localparam int MASK_LSB = 0;

  typedef struct packed {
    logic [FRAME_W-1:0] frame;
    logic [MASK_W-1:0] mask;
  } pibcw_desc_t;

  typedef struct packed {
    logic done;
    logic [2:0] uframe;
    logic [BYTES_W-1:0] bytes;
  } pibcw_rx_t;

  typedef struct packed {
    logic [63:0] pairTop;
    logic [63:0] pairMid;
  } pibcw_wb_t;

  typedef enum logic [1:0] {PIBCW_IDLE, PIBCW_ACTIVE, PIBCW_WRITE} pibcw_state_t;

  function automatic logic [CNT_W-1:0] pibcw_sat(input logic [BYTES_W-1:0] b);
    pibcw_sat = (b > BYTES_W'(CNT_MAX)) ? CNT_MAX : b[CNT_W-1:0];
  endfunction : pibcw_sat
endpackage : pibcw_pkg

// ==== hdl/pibcw_count_field.sv ====
`timescale 1ns/1ps
module pibcw_count_field (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic capture,
  input wire logic [pibcw_pkg::BYTES_W-1:0] bytes,
  output logic [pibcw_pkg::CNT_W-1:0] count
);
  import pibcw_pkg::*;

  logic [CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (capture) begin
      next_count = pibcw_sat(bytes);
    end else if (clear) begin
      next_count = CNT_RST;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= CNT_RST;
    end else begin
      count <= next_count;
    end
  end
endmodule : pibcw_count_field

// ==== hdl/pibcw_writeback.sv ====
`timescale 1ns/1ps
module pibcw_writeback (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic loadDesc,
  input pibcw_pkg::pibcw_desc_t descIn,
  input wire logic [pibcw_pkg::FRAME_W-1:0] busFrame,
  input wire logic uframeStart,
  input wire logic [2:0] curUframe,
  output logic txnReq,
  input pibcw_pkg::pibcw_rx_t rxIn,
  output logic wbValid,
  input wire logic wbReady,
  output pibcw_pkg::pibcw_wb_t wbData,
  output logic retired,
  output logic busy
);
  import pibcw_pkg::*;

  pibcw_state_t state;
  pibcw_state_t next_state;
  logic [MASK_W-1:0] mask;
  logic [MASK_W-1:0] next_mask;
  logic [FRAME_W-1:0] frame;
  logic [FRAME_W-1:0] next_frame;
  logic next_txnReq;
  pibcw_wb_t next_wbData;
  logic [UF_NUM-1:0][CNT_W-1:0] cnt;
  logic [UF_NUM-1:0] captureVec;
  logic frameMatch;
  logic hit;
  logic clearCnt;

  // Only a matching frame opens the mask for checking
  assign frameMatch = (frame == busFrame);
  assign hit = rxIn.done && (state == PIBCW_ACTIVE) && mask[rxIn.uframe]
    && frameMatch;
  assign clearCnt = loadDesc && (state == PIBCW_IDLE);

  genvar gi;
  generate
    for (gi = 0; gi < UF_NUM; gi++) begin : gCount
      assign captureVec[gi] = hit && (rxIn.uframe == 3'(gi));
      pibcw_count_field uCount (
        .core_clk(core_clk),
        .rst(rst),
        .clear(clearCnt),
        .capture(captureVec[gi]),
        .bytes(rxIn.bytes),
        .count(cnt[gi])
      );
    end
  endgenerate

  // Descriptor state and retirement sequencing
  always_comb begin
    next_state = state;
    next_mask = mask;
    next_frame = frame;
    case (state)
      PIBCW_IDLE: begin
        if (loadDesc) begin
          next_mask = descIn.mask;
          next_frame = descIn.frame;
          next_state = PIBCW_ACTIVE;
        end
      end
      PIBCW_ACTIVE: begin
        if (hit) begin
          next_mask[rxIn.uframe] = 1'b0;
        end
        if (mask == MASK_RST) begin
          next_state = PIBCW_WRITE;
        end
      end
      PIBCW_WRITE: begin
        if (wbReady) begin
          next_state = PIBCW_IDLE;
        end
      end
      default: begin
        next_state = PIBCW_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= PIBCW_IDLE;
      mask <= MASK_RST;
      frame <= FRAME_RST;
    end else begin
      state <= next_state;
      mask <= next_mask;
      frame <= next_frame;
    end
  end

  // Transaction request at a microframe start whose mask bit is set, in the matching frame
  always_comb begin
    next_txnReq = uframeStart && (state == PIBCW_ACTIVE)
      && frameMatch && mask[curUframe];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txnReq <= 1'b0;
    end else begin
      txnReq <= next_txnReq;
    end
  end

  // Descriptor words assembled from the counts
  always_comb begin
    next_wbData.pairTop = PAIR_RST;
    next_wbData.pairMid = PAIR_RST;
    next_wbData.pairTop[UF7_LSB +: CNT_W] = cnt[7];
    next_wbData.pairTop[UF6_LSB +: CNT_W] = cnt[6];
    next_wbData.pairTop[UF5H_LSB +: 8] = cnt[5][11:4];
    next_wbData.pairTop[UF5L_LSB +: 4] = cnt[5][3:0];
    next_wbData.pairTop[UF4_LSB +: CNT_W] = cnt[4];
    next_wbData.pairTop[UF3_LSB +: CNT_W] = cnt[3];
    next_wbData.pairTop[UF2H_LSB +: 4] = cnt[2][11:8];
    next_wbData.pairMid[UF2L_LSB +: 8] = cnt[2][7:0];
    next_wbData.pairMid[UF1_LSB +: CNT_W] = cnt[1];
    next_wbData.pairMid[UF0_LSB +: CNT_W] = cnt[0];
    next_wbData.pairMid[MASK_LSB +: MASK_W] = mask;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wbData <= '0;
    end else begin
      wbData <= next_wbData;
    end
  end

  assign wbValid = (state == PIBCW_WRITE);
  assign retired = wbValid && wbReady;
  assign busy = (state != PIBCW_IDLE);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence capUf(int n);
    hit && (rxIn.uframe == 3'(n));
  endsequence

  sequence noCapture;
    !hit && !clearCnt;
  endsequence

  uf7Field_a: assert property (
    capUf(7) |-> ##2 wbData.pairTop[63:52] == pibcw_sat($past(rxIn.bytes, 2)))
    else $error("uf7 field wrong");
  uf6Field_a: assert property (
    capUf(6) |-> ##2 wbData.pairTop[51:40] == pibcw_sat($past(rxIn.bytes, 2)))
    else $error("uf6 field wrong");
  uf5High_a: assert property (
    capUf(5) |-> ##2 {4'h0, wbData.pairTop[39:32]} ==
      (pibcw_sat($past(rxIn.bytes, 2)) >> 4))
    else $error("uf5 high wrong");
  uf5Low_a: assert property (
    capUf(5) |-> ##2 {8'h00, wbData.pairTop[31:28]} ==
      (pibcw_sat($past(rxIn.bytes, 2)) & 12'h00F))
    else $error("uf5 low wrong");
  uf4Field_a: assert property (
    capUf(4) |-> ##2 wbData.pairTop[27:16] == pibcw_sat($past(rxIn.bytes, 2)))
    else $error("uf4 field wrong");
  uf3Field_a: assert property (
    capUf(3) |-> ##2 wbData.pairTop[15:4] == pibcw_sat($past(rxIn.bytes, 2)))
    else $error("uf3 field wrong");
  uf2Split_a: assert property (
    capUf(2) |-> ##2 {wbData.pairTop[3:0], wbData.pairMid[63:56]} ==
      pibcw_sat($past(rxIn.bytes, 2)))
    else $error("uf2 split wrong");
  uf2Low_a: assert property (
    capUf(2) ##1 noCapture |-> ##1 wbData.pairMid[63:56] == $past(cnt[2][7:0]))
    else $error("uf2 low wrong");
  uf1Field_a: assert property (
    capUf(1) |-> ##2 wbData.pairMid[55:44] == pibcw_sat($past(rxIn.bytes, 2)))
    else $error("uf1 field wrong");
  uf0Field_a: assert property (
    capUf(0) |-> ##2 wbData.pairMid[43:32] == pibcw_sat($past(rxIn.bytes, 2)))
    else $error("uf0 field wrong");
  countHold_a: assert property (
    noCapture |=> $stable(cnt))
    else $error("count changed without hit");
  txnGate_a: assert property (
    txnReq |-> $past(mask[curUframe]) && $past(frame == busFrame))
    else $error("request without mask or frame");
  maskClear_a: assert property (
    hit |=> !mask[$past(rxIn.uframe)] ##1 !wbData.pairMid[$past(rxIn.uframe, 2)])
    else $error("mask bit not cleared");
  retireDone_a: assert property (
    wbValid |-> (mask == MASK_RST) && (wbData.pairMid[7:0] == MASK_RST))
    else $error("retire with pending mask");
endmodule : pibcw_writeback

// ==== verification/pibcw_host_model.sv ====
`timescale 1ns/1ps
module pibcw_host_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic go,
  input wire pibcw_pkg::pibcw_desc_t descReq,
  input wire logic [3:0] stall,
  input wire logic wbValid,
  input wire logic retired,
  output logic loadDesc,
  output pibcw_pkg::pibcw_desc_t descIn,
  output logic wbReady
);
  import pibcw_pkg::*;
  logic [3:0] waitN;
  // Software sets only the frame and mask bits and never seeds counts
  assign loadDesc = go;
  assign descIn = descReq;
  // Accepts write-back after a chosen stall
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      waitN <= 4'h0;
      wbReady <= 1'b0;
    end else begin
      waitN <= (wbValid && !retired) ? waitN + 4'h1 : 4'h0;
      wbReady <= wbValid && !retired && (waitN >= stall);
    end
  end
endmodule : pibcw_host_model

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
  import pibcw_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic uframeStart = 1'b0;
  logic loadDesc, txnReq, wbValid, wbReady, retired, busy;
  logic [FRAME_W-1:0] busFrame = 5'h03;
  logic [2:0] curUframe = 3'h0;
  logic [3:0] stall = 4'h0;
  pibcw_desc_t descReq = 13'h0000;
  pibcw_desc_t descIn;
  pibcw_rx_t rxIn = 20'h00000;
  pibcw_wb_t wbData;
  int badCount = 0;
  int checked = 0;
  int cycles = 0;
  always #50 core_clk = ~core_clk;
  pibcw_writeback uut (.core_clk, .rst, .loadDesc, .descIn, .busFrame, .uframeStart,
    .curUframe, .txnReq, .rxIn, .wbValid, .wbReady, .wbData, .retired, .busy);
  pibcw_host_model host (.core_clk, .rst, .go, .descReq, .stall, .wbValid, .retired,
    .loadDesc, .descIn, .wbReady);
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic cyc();
    @(posedge core_clk);
    #10;
  endtask : cyc
  task automatic load(input logic [4:0] fr, input logic [7:0] m);
    descReq = {fr, m};
    go = 1'b1;
    cyc();
    go = 1'b0;
    chk("busy", {63'h0, busy}, 64'h1);
    cyc();
  endtask : load
  task automatic req(input logic [2:0] uf, input logic exp);
    uframeStart = 1'b1;
    curUframe = uf;
    cyc();
    uframeStart = 1'b0;
    chk("txnReq", {63'h0, txnReq}, {63'h0, exp});
  endtask : req
  task automatic rx(input logic [2:0] uf, input logic [15:0] b);
    rxIn = {1'b1, uf, b};
    cyc();
    rxIn.done = 1'b0;
    cyc();
  endtask : rx
  task automatic retire(input logic [63:0] top, input logic [63:0] mid);
    int n;
    n = 0;
    while (wbValid !== 1'b1 && n < 20) begin
      cyc();
      n++;
    end
    chk("wbValid", {63'h0, wbValid}, 64'h1);
    chk("pairTop", wbData.pairTop, top);
    chk("pairMid", wbData.pairMid, mid);
    while (retired !== 1'b1 && n < 40) begin
      cyc();
      n++;
    end
    chk("retired", {63'h0, retired}, 64'h1);
    cyc();
    chk("busy", {63'h0, busy}, 64'h0);
  endtask : retire
  task automatic full_frame();
    logic [11:0] c[8];
    load(5'h03, 8'hFF);
    for (int k = 0; k < 8; k++) begin
      c[k] = (k == 5) ? 12'hFFF : 12'(12'h111 * (k + 1));
      req(3'(k), 1'b1);
      rx(3'(k), (k == 5) ? 16'h1234 : 16'(c[k]));
      chk("mask", {56'h0, wbData.pairMid[7:0]}, {56'h0, 8'hFE << k});
    end
    stall = 4'h3;
    retire({c[7], c[6], c[5], c[4], c[3], c[2][11:8]}, {c[2][7:0], c[1], c[0], 32'h0});
  endtask : full_frame
  task automatic refused();
    stall = 4'h0;
    load(5'h04, 8'h05);
    req(3'h0, 1'b0);
    rx(3'h0, 16'h00AB);
    busFrame = 5'h04;
    req(3'h1, 1'b0);
    rx(3'h1, 16'h00CD);
    chk("pairMid", wbData.pairMid, 64'h5);
    chk("pairTop", wbData.pairTop, 64'h0);
    req(3'h0, 1'b1);
    rx(3'h0, 16'h00AB);
    rx(3'h2, 16'h09C3);
    retire(64'h9, {8'hC3, 12'h000, 12'h0AB, 32'h0});
  endtask : refused
  task automatic empty_mask();
    load(5'h07, 8'h00);
    descReq = {5'h01, 8'hFF};
    go = 1'b1;
    cyc();
    go = 1'b0;
    retire(64'h0, 64'h0);
  endtask : empty_mask
  task automatic giveVerdict();
    if (badCount == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : giveVerdict
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      badCount++;
      giveVerdict();
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    #10;
    rst = 1'b0;
    full_frame();
    refused();
    empty_mask();
    giveVerdict();
  end
endmodule : tb
